/* File: common/init_seq_pkg.sv */
// Types shared by the initialisation sequencer
`default_nettype none
package init_seq_pkg;
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_FUSE_READ = 3'b001,
		ST_FUSE_OFF = 3'b010,
		ST_PHASE2 = 3'b011,
		ST_NORMAL = 3'b100
	} init_state_t;
endpackage : init_seq_pkg
`default_nettype wire

/* File: common/init_seq_regs.svh */
// Timing counts and field positions for the power-on initialisation sequencer
`ifndef INIT_SEQ_REGS_SVH
`define INIT_SEQ_REGS_SVH

`define CLK_FREQ_HZ 25000000
`define PHASE1_TIME_US 800
`define PHASE2_TIME_US 3000
`define PHASE2_HPF_TIME_US 200000
`define PHASE1_CYCLES ((`PHASE1_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define PHASE2_CYCLES ((`PHASE2_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define PHASE2_HPF_CYCLES ((`PHASE2_HPF_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define FUSE_DEPTH 16
`define FUSE_ADDR_W 4
`define FUSE_DATA_W 8
`define STATUS_INIT_BIT 0
`define STATUS_RESET_VAL 8'h01
`define NON_ACCEL_WORD 10'h3ff

`endif

/* File: design/fuse_mirror_mem.sv */
// Mirror register array holding the copied fuse contents
`default_nettype none
`include "init_seq_regs.svh"
module fuse_mirror_mem (
	// Clock
	input wire logic clk_in,
	input wire logic ce_in,
	// Write port
	input wire logic wr_en_in,
	input wire logic [`FUSE_ADDR_W-1:0] wr_addr_in,
	input wire logic [`FUSE_DATA_W-1:0] wr_data_in,
	// Read port
	input wire logic [`FUSE_ADDR_W-1:0] rd_addr_in,
	output logic [`FUSE_DATA_W-1:0] rd_data_out
);
	logic [`FUSE_DATA_W-1:0] mem_ff [`FUSE_DEPTH];

	always_ff @(posedge clk_in) begin
		if (ce_in && wr_en_in) begin
			mem_ff[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			rd_data_out <= mem_ff[rd_addr_in];
		end
	end
endmodule : fuse_mirror_mem
`default_nettype wire

/* File: design/power_on_init_sequencer.sv */
// Power-on reset and two-phase initialisation sequencer
// Operation
// [RULE_01] Hold internal reset until supply and both regulator rails are good, then start init.
// [RULE_02] Run the whole initialisation after every reset of any origin.
// [RULE_03] Phase one reads every fuse word into the mirror registers.
// [RULE_04] After mirroring, switch the fuse array power off.
// [RULE_05] Phase two waits for the reference and also settles the high-pass filter if selected.
// [RULE_06] During phase one SPI transfers are ignored with no response.
// [RULE_07] During phase two SPI register reads and writes work normally.
// [RULE_08] An acceleration request in phase two returns a non-acceleration word.
// [RULE_09] Phase one ends about 800 us after reset release.
// [RULE_10] Phase two lasts about 3 ms, or about 200 ms with high-pass select set.
// [RULE_11] The init-in-progress flag is set at reset and clears when phase two ends.
// [RULE_12] The host polls the flag and trusts acceleration data only once it is clear.
// [RULE_13] Normal mode is entered when powered and the programming pin is not above supply.
`default_nettype none
`include "init_seq_regs.svh"
module power_on_init_sequencer
	import init_seq_pkg::*;
#(
	parameter int unsigned PHASE1_CNT = `PHASE1_CYCLES,
	parameter int unsigned PHASE2_CNT = `PHASE2_CYCLES,
	parameter int unsigned PHASE2_HPF_CNT = `PHASE2_HPF_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Voltage comparators and mode pin (asynchronous)
	input wire logic main_supply_good_in,
	input wire logic digital_rail_good_in,
	input wire logic analog_regulator_rail_good_in,
	input wire logic program_voltage_high_in,
	// Filter configuration
	input wire logic highpass_select_in,
	// Fuse array
	output logic fuse_power_out,
	output logic fuse_rd_en_out,
	output logic [`FUSE_ADDR_W-1:0] fuse_addr_out,
	input wire logic [`FUSE_DATA_W-1:0] fuse_data_in,
	// Mirror read-back
	input wire logic [`FUSE_ADDR_W-1:0] mirror_addr_in,
	output logic [`FUSE_DATA_W-1:0] mirror_data_out,
	// SPI gating
	input wire logic spi_req_in,
	input wire logic spi_accel_req_in,
	output logic spi_respond_out,
	output logic accel_block_out,
	output logic [9:0] accel_word_out,
	input wire logic [9:0] accel_data_in,
	// Status
	output logic [7:0] device_status_reg_out,
	output logic init_in_progress_out,
	output logic internal_reset_out,
	output logic hpf_init_out,
	output logic normal_mode_out,
	output logic [2:0] state_out
);
	//----------------------------------------
	// Pin synchronisers
	//----------------------------------------
	logic [3:0] pins_meta_ff;
	logic [3:0] pins_sync_ff;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pins_meta_ff <= 4'h0;
			pins_sync_ff <= 4'h0;
		end else if (ce_in) begin
			pins_meta_ff <= {program_voltage_high_in, analog_regulator_rail_good_in,
				digital_rail_good_in, main_supply_good_in};
			pins_sync_ff <= pins_meta_ff;
		end
	end

	logic power_good;
	// Filter-free AND of synchronised levels; a rail dropping re-enters reset
	assign power_good = &pins_sync_ff[2:0]; // see [RULE_01]

	//----------------------------------------
	// Sequencer
	//----------------------------------------
	init_state_t state_ff;
	init_state_t nxt_state;
	logic [23:0] cnt_ff;
	logic [`FUSE_ADDR_W-1:0] fuse_idx_ff;
	logic fuse_pend_ff;
	logic hpf_ff;
	logic [23:0] p2_limit;

	assign p2_limit = hpf_ff ? 24'(PHASE2_HPF_CNT - 1) : 24'(PHASE2_CNT - 1); // see [RULE_10]

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_RESET: begin
				if (power_good) begin
					nxt_state = ST_FUSE_READ; // see [RULE_01]
				end
			end
			ST_FUSE_READ: begin
				if (fuse_pend_ff && fuse_idx_ff == `FUSE_ADDR_W'(`FUSE_DEPTH - 1)) begin
					nxt_state = ST_FUSE_OFF;
				end
			end
			ST_FUSE_OFF: begin
				if (cnt_ff >= 24'(PHASE1_CNT - 1)) begin
					nxt_state = ST_PHASE2; // see [RULE_09]
				end
			end
			ST_PHASE2: begin
				if (cnt_ff >= p2_limit) begin
					nxt_state = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				nxt_state = ST_NORMAL;
			end
			default: begin
				nxt_state = ST_RESET;
			end
		endcase
		// Any loss of a rail restarts the whole sequence
		if (!power_good) begin
			nxt_state = ST_RESET; // see [RULE_02]
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_ff <= ST_RESET; // see [RULE_02]
		end else if (ce_in) begin
			state_ff <= nxt_state;
		end
	end

	// Phase timer counts from reset release through phase one, restarts at phase two
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_ff <= 24'h000000;
		end else if (ce_in) begin
			if (nxt_state != state_ff && nxt_state inside {ST_PHASE2, ST_RESET}) begin
				cnt_ff <= 24'h000000;
			end else if (state_ff != ST_RESET && state_ff != ST_NORMAL) begin
				cnt_ff <= cnt_ff + 24'h000001;
			end
		end
	end

	// Fuse walk: address issued, data captured one cycle later
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			fuse_idx_ff <= `FUSE_ADDR_W'(0);
			fuse_pend_ff <= 1'b0;
		end else if (ce_in) begin
			if (state_ff == ST_FUSE_READ) begin
				fuse_pend_ff <= 1'b1;
				if (fuse_pend_ff) begin
					fuse_idx_ff <= fuse_idx_ff + `FUSE_ADDR_W'(1); // see [RULE_03]
				end
			end else begin
				fuse_idx_ff <= `FUSE_ADDR_W'(0);
				fuse_pend_ff <= 1'b0;
			end
		end
	end

	logic [`FUSE_ADDR_W-1:0] fuse_rd_addr;
	assign fuse_rd_addr = fuse_pend_ff ? fuse_idx_ff + `FUSE_ADDR_W'(1) : fuse_idx_ff;

	fuse_mirror_mem u_mirror (
		.clk_in(clk_in),
		.ce_in(ce_in),
		.wr_en_in(state_ff == ST_FUSE_READ && fuse_pend_ff), // see [RULE_03]
		.wr_addr_in(fuse_idx_ff),
		.wr_data_in(fuse_data_in),
		.rd_addr_in(mirror_addr_in),
		.rd_data_out(mirror_data_out)
	);

	// High-pass select latched on entry to phase two so the duration is stable
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			hpf_ff <= 1'b0;
		end else if (ce_in && state_ff == ST_FUSE_OFF) begin
			hpf_ff <= highpass_select_in; // see [RULE_05]
		end
	end

	//----------------------------------------
	// Outputs
	//----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			fuse_power_out <= 1'b0;
			fuse_rd_en_out <= 1'b0;
			fuse_addr_out <= `FUSE_ADDR_W'(0);
		end else if (ce_in) begin
			fuse_power_out <= (nxt_state == ST_FUSE_READ); // see [RULE_04]
			fuse_rd_en_out <= (nxt_state == ST_FUSE_READ);
			fuse_addr_out <= (nxt_state == ST_FUSE_READ) ? fuse_rd_addr : `FUSE_ADDR_W'(0);
		end
	end

	logic in_phase1;
	logic in_phase2;
	assign in_phase1 = state_ff inside {ST_RESET, ST_FUSE_READ, ST_FUSE_OFF};
	assign in_phase2 = (state_ff == ST_PHASE2);

	// SPI answered outside phase one only
	assign spi_respond_out = spi_req_in && !in_phase1; // see [RULE_06] see [RULE_07]
	assign accel_block_out = !normal_mode_out; // see [RULE_08]

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			accel_word_out <= `NON_ACCEL_WORD;
		end else if (ce_in && spi_accel_req_in) begin
			accel_word_out <= in_phase2 ? `NON_ACCEL_WORD : accel_data_in; // see [RULE_08]
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			device_status_reg_out <= `STATUS_RESET_VAL; // see [RULE_11]
			init_in_progress_out <= 1'b1;
			normal_mode_out <= 1'b0;
			hpf_init_out <= 1'b0;
		end else if (ce_in) begin
			device_status_reg_out <= 8'h00;
			device_status_reg_out[`STATUS_INIT_BIT] <= (nxt_state != ST_NORMAL); // see [RULE_11]
			init_in_progress_out <= (nxt_state != ST_NORMAL);
			normal_mode_out <= (nxt_state == ST_NORMAL) && !pins_sync_ff[3]; // see [RULE_13]
			hpf_init_out <= (nxt_state == ST_PHASE2) && (state_ff == ST_PHASE2 ? hpf_ff
				: highpass_select_in); // see [RULE_05]
		end
	end

	assign internal_reset_out = (state_ff == ST_RESET); // see [RULE_01]
	assign state_out = state_ff;
endmodule : power_on_init_sequencer
`default_nettype wire

/* File: tb/fuse_array_model.sv */
// Fuse array model presenting the addressed word in the same cycle
`default_nettype none
`include "init_seq_regs.svh"
module fuse_array_model (
	input wire logic fuse_power_in,
	input wire logic [`FUSE_ADDR_W-1:0] fuse_addr_in,
	output logic [`FUSE_DATA_W-1:0] fuse_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [`FUSE_DATA_W-1:0] word;
	assign word = {fuse_addr_in ^ 4'ha, fuse_addr_in};
	// Unpowered array shows the inverse so a read without power never looks valid
	assign fuse_data_out = fuse_power_in ? word : ~word;
endmodule : fuse_array_model
`default_nettype wire

/* File: tb/init_seq_props.sv */
// Checker for the initialisation sequencer ports
`default_nettype none
module init_seq_props (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic analog_regulator_rail_good_in,
	input wire logic spi_req_in,
	input wire logic spi_accel_req_in,
	input wire logic fuse_power_out,
	input wire logic [3:0] fuse_addr_out,
	input wire logic spi_respond_out,
	input wire logic accel_block_out,
	input wire logic [9:0] accel_word_out,
	input wire logic [7:0] device_status_reg_out,
	input wire logic init_in_progress_out,
	input wire logic [2:0] state_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence fuse_on_s; $rose(fuse_power_out); endsequence
	sequence fuse_hold_s; fuse_power_out [*8]; endsequence
	spi_gate_a: assert property (spi_respond_out
		== (spi_req_in && state_out > 3'h2))
		else $error("spi gate wrong");
	fuse_off_a: assert property (state_out != 3'h1
		&& state_out != 3'h2 |-> !fuse_power_out)
		else $error("fuse power on");
	fuse_hold_a: assert property (fuse_on_s |-> fuse_hold_s)
		else $error("fuse read cut short");
	fuse_start_a: assert property (fuse_on_s
		|-> state_out == 3'h1 && fuse_addr_out == 4'h0)
		else $error("fuse read start wrong");
	accel_sub_a: assert property (spi_accel_req_in && state_out == 3'h3
		|=> accel_word_out == 10'h3ff)
		else $error("accel word not replaced");
	accel_gate_a: assert property (state_out != 3'h4 |-> accel_block_out)
		else $error("accel not blocked");
	init_clear_a: assert property ($fell(init_in_progress_out)
		|-> state_out == 3'h4)
		else $error("init flag cleared early");
	status_bit_a: assert property (device_status_reg_out[0]
		== init_in_progress_out)
		else $error("status bit mismatch");
	state_order_a: assert property (state_out != $past(state_out)
		&& state_out != 3'h0 |-> state_out == $past(state_out) + 3'h1)
		else $error("state order wrong");
	rail_loss_a: assert property (!analog_regulator_rail_good_in
		|-> ##[1:4] state_out == 3'h0)
		else $error("rail loss ignored");
endmodule : init_seq_props
`default_nettype wire

/* File: tb/tb.sv */
// Bench for the power-on initialisation sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic ce = 1'b1;
	logic [2:0] rail = 3'h0;
	logic prog = 1'b0;
	logic hps = 1'b0;
	logic req = 1'b0;
	logic acc = 1'b0;
	logic [3:0] maddr = 4'h0;
	logic [9:0] adata = 10'h155;
	logic fpow, frd, resp, blk, init, irst, hpf, norm;
	logic [3:0] faddr;
	logic [7:0] fdata, mdata, stat;
	logic [9:0] aword;
	logic [2:0] st;
	int error_cnt = 0;
	int compares = 0;
	int n;
	power_on_init_sequencer #(.PHASE1_CNT(40), .PHASE2_CNT(60), .PHASE2_HPF_CNT(100))
		power_on_init_sequencer_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
		.main_supply_good_in(rail[0]), .digital_rail_good_in(rail[1]),
		.analog_regulator_rail_good_in(rail[2]), .program_voltage_high_in(prog),
		.highpass_select_in(hps), .fuse_power_out(fpow), .fuse_rd_en_out(frd),
		.fuse_addr_out(faddr), .fuse_data_in(fdata), .mirror_addr_in(maddr),
		.mirror_data_out(mdata), .spi_req_in(req), .spi_accel_req_in(acc),
		.spi_respond_out(resp), .accel_block_out(blk), .accel_word_out(aword),
		.accel_data_in(adata), .device_status_reg_out(stat), .init_in_progress_out(init),
		.internal_reset_out(irst), .hpf_init_out(hpf), .normal_mode_out(norm), .state_out(st));
	fuse_array_model fuse_array_model_i (.fuse_power_in(fpow),
		.fuse_addr_in(faddr), .fuse_data_out(fdata));
	initial forever #20 clk_in = ~clk_in;
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic ws(input logic [2:0] s);
		n = 0;
		while (st !== s && n < 500) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		if (st !== s) begin
			error_cnt++;
			$display("wrong value state expected %h seen %h", s, st);
		end
	endtask : ws
	task automatic boot(input logic hp);
		@(posedge clk_in);
		hps <= hp;
		req <= 1'b1;
		rail <= 3'h7;
		ws(3'h1);
		chk("respond", 0, resp);
		chk("fuse power", 1, fpow);
		chk("fuse read", 1, frd);
		ws(3'h3);
		chk("phase one", 40, n);
		chk("fuse off", 0, fpow);
		chk("fuse read", 0, frd);
		chk("respond", 1, resp);
		@(posedge clk_in);
		acc <= 1'b1;
		@(posedge clk_in);
		acc <= 1'b0;
		#1;
		chk("accel", 10'h3ff, aword);
		chk("hpf", hp, hpf);
		chk("status", 8'h01, stat);
		ws(3'h4);
		chk("phase two", hp ? 98 : 58, n);
		chk("hpf", 0, hpf);
		chk("status", 8'h00, stat);
		chk("normal", 1, norm);
		@(posedge clk_in);
		acc <= 1'b1;
		@(posedge clk_in);
		acc <= 1'b0;
		#1;
		chk("accel", adata, aword);
	endtask : boot
	task automatic mirror;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_in);
			maddr <= 4'(i);
			@(posedge clk_in);
			#1;
			chk("mirror", {2'h0, 4'(i) ^ 4'ha, 4'(i)}, mdata);
		end
	endtask : mirror
	task automatic mode_pin;
		@(posedge clk_in);
		prog <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		chk("normal", 0, norm);
		@(posedge clk_in);
		prog <= 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
		chk("normal", 1, norm);
	endtask : mode_pin
	task automatic rail_drop;
		@(posedge clk_in);
		rail <= 3'h3;
		repeat (4) @(posedge clk_in);
		#1;
		chk("state", 0, st);
		chk("status", 8'h01, stat);
		chk("respond", 0, resp);
	endtask : rail_drop
	task automatic soft_reset;
		@(posedge clk_in);
		srst_in <= 1'b1;
		@(posedge clk_in);
		srst_in <= 1'b0;
		#1;
		chk("state", 0, st);
		chk("internal reset", 1, irst);
		chk("status", 8'h01, stat);
		chk("accel", 10'h3ff, aword);
	endtask : soft_reset
	// Main supply is dropped so the rail assertion stays quiet while frozen
	task automatic freeze;
		@(posedge clk_in);
		ce <= 1'b0;
		rail <= 3'h6;
		repeat (6) @(posedge clk_in);
		#1;
		chk("frozen state", 4, st);
		chk("frozen normal", 1, norm);
		@(posedge clk_in);
		ce <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		chk("state", 0, st);
		chk("status", 8'h01, stat);
	endtask : freeze
	initial begin
		repeat (20) @(posedge clk_in);
		srst_in <= 1'b0;
		#1;
		chk("internal reset", 1, irst);
		chk("status", 8'h01, stat);
		boot(1'b0);
		mirror;
		mode_pin;
		rail_drop;
		boot(1'b1);
		soft_reset;
		boot(1'b0);
		freeze;
		end_sim;
	end
	// Whole run is about 500 cycles; give up after ten times that
	initial begin
		#200000;
		error_cnt++;
		end_sim;
	end
	task automatic end_sim;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
endmodule : tb
bind power_on_init_sequencer init_seq_props init_seq_props_i (.*);
`default_nettype wire
